// *** verilog/adcls_pkg.sv ***
package adcls_pkg;
  // ----------------------------------------
  // Register map and field layout
  // ----------------------------------------
  localparam logic [7:0]  OFS_CFG_A      = 8'h15;
  localparam logic [7:0]  OFS_CFG_B      = 8'h16;
  localparam int          CFGA_LANES_BIT = 0;
  localparam int          CFGA_TEST_BIT  = 4;
  localparam int          CFGB_SELF_BIT  = 0;
  localparam int          CFGB_MANCH_BIT = 1;
  localparam int          CFGB_DIFF_BIT  = 3;
  localparam int          CFGB_CNT_LSB   = 4;
  localparam logic [7:0]  RST_CFG_A      = 8'h00;
  localparam logic [7:0]  RST_CFG_B      = 8'h00;
  localparam logic [7:0]  CFGA_MASK      = 8'h11;
  localparam logic [7:0]  CFGB_MASK      = 8'hfb;
  // ----------------------------------------
  // Result and link figures
  // ----------------------------------------
  localparam int          RESULT_W       = 20;
  localparam logic [19:0] TEST_PATTERN   = 20'hac5d6;
  localparam int          LANE_MBPS_MAX  = 800;
  localparam logic [3:0]  CLK_SINGLE     = 4'ha;
  localparam logic [3:0]  CLK_DUAL       = 4'h5;
  localparam logic [3:0]  CLK_MANCH      = 4'ha;

  typedef struct packed {
    logic       two_lanes;
    logic       test_en;
    logic       self_clk;
    logic       manch;
    logic       diff_strobe;
    logic [3:0] load_cnt;
  } adcls_cfg_t;

  typedef struct packed {
    logic l1_fall;
    logic l1_rise;
    logic l2_fall;
    logic l2_rise;
  } adcls_pairs_t;

  typedef enum logic {
    SH_IDLE = 1'b0,
    SH_RUN  = 1'b1
  } adcls_shift_t;
endpackage : adcls_pkg

// *** verilog/adcls_serializer.sv ***
`timescale 1ns/1ns
`default_nettype none
module adcls_serializer #(
  parameter int RESULT_W = adcls_pkg::RESULT_W
) (
  // System clock and reset
  input  wire logic                clk_sys,
  input  wire logic                sys_rst,
  // Configuration register port
  input  wire logic                reg_wr_en,
  input  wire logic [7:0]          reg_addr,
  input  wire logic [7:0]          reg_wdata,
  output logic      [7:0]          reg_rdata,
  // Conversion results from the converter core
  input  wire logic                result_valid,
  input  wire logic [RESULT_W-1:0] result_data,
  output logic                     result_ready,
  // Interface clock and convert strobe pins
  input  wire logic                link_clk,
  input  wire logic                convert_strobe_p,
  input  wire logic                convert_strobe_n,
  // Lanes and echo clock
  output logic                     first_lane_p,
  output logic                     first_lane_n,
  output logic                     second_lane_p,
  output logic                     second_lane_n,
  output logic                     second_lane_en,
  output logic                     echo_clock_out_p,
  output logic                     echo_clock_out_n,
  output logic                     echo_clock_out_en
);
  // ----------------------------------------
  // Configuration registers
  // ----------------------------------------
  logic [7:0] cfg_a_ff;
  logic [7:0] cfg_b_ff;
  logic [7:0] rdata_ff;
  adcls_pkg::adcls_cfg_t cfg_sys;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      cfg_a_ff <= adcls_pkg::RST_CFG_A;
      cfg_b_ff <= adcls_pkg::RST_CFG_B;
    end else if (reg_wr_en && reg_addr == adcls_pkg::OFS_CFG_A) begin
      cfg_a_ff <= reg_wdata & adcls_pkg::CFGA_MASK;
    end else if (reg_wr_en && reg_addr == adcls_pkg::OFS_CFG_B) begin
      cfg_b_ff <= reg_wdata & adcls_pkg::CFGB_MASK;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      rdata_ff <= 8'h00;
    end else begin
      case (reg_addr)
        adcls_pkg::OFS_CFG_A: rdata_ff <= cfg_a_ff;
        adcls_pkg::OFS_CFG_B: rdata_ff <= cfg_b_ff;
        default:              rdata_ff <= 8'h00;
      endcase
    end
  end
  assign reg_rdata = rdata_ff;

  assign cfg_sys.two_lanes   = cfg_a_ff[adcls_pkg::CFGA_LANES_BIT];
  assign cfg_sys.test_en     = cfg_a_ff[adcls_pkg::CFGA_TEST_BIT];
  assign cfg_sys.self_clk    = cfg_b_ff[adcls_pkg::CFGB_SELF_BIT];
  assign cfg_sys.manch       = cfg_b_ff[adcls_pkg::CFGB_MANCH_BIT];
  assign cfg_sys.diff_strobe = cfg_b_ff[adcls_pkg::CFGB_DIFF_BIT];
  assign cfg_sys.load_cnt    = cfg_b_ff[adcls_pkg::CFGB_CNT_LSB +: 4];

  // ----------------------------------------
  // Two-entry result buffer
  // ----------------------------------------
  logic [RESULT_W-1:0] buf_mem_ff [2];
  logic                buf_wr_ff;
  logic                buf_rd_ff;
  logic [1:0]          buf_cnt_ff;
  logic                buf_push;
  logic                buf_pop;
  logic                hs_busy;

  assign result_ready = (buf_cnt_ff != 2'h2);
  assign buf_push     = result_valid && result_ready;
  assign buf_pop      = (buf_cnt_ff != 2'h0) && !hs_busy;

  always_ff @(posedge clk_sys) begin
    if (buf_push) begin
      buf_mem_ff[buf_wr_ff] <= result_data;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      buf_wr_ff  <= 1'b0;
      buf_rd_ff  <= 1'b0;
      buf_cnt_ff <= 2'h0;
    end else begin
      if (buf_push) begin
        buf_wr_ff <= ~buf_wr_ff;
      end
      if (buf_pop) begin
        buf_rd_ff <= ~buf_rd_ff;
      end
      buf_cnt_ff <= buf_cnt_ff + {1'b0, buf_push} - {1'b0, buf_pop};
    end
  end

  // ----------------------------------------
  // Word crossing by toggle handshake
  // ----------------------------------------
  // The data word stays put while a toggle is in flight, so the link side
  // samples it only after the toggle has settled through two stages.
  logic                hs_req_ff;
  logic [RESULT_W-1:0] hs_data_ff;
  logic                ack_meta_ff;
  logic                ack_sync_ff;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      hs_req_ff  <= 1'b0;
      hs_data_ff <= '0;
    end else if (buf_pop) begin
      hs_req_ff  <= ~hs_req_ff;
      hs_data_ff <= buf_mem_ff[buf_rd_ff];
    end
  end

  logic ack_ff;
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      ack_meta_ff <= 1'b0;
      ack_sync_ff <= 1'b0;
    end else begin
      ack_meta_ff <= ack_ff;
      ack_sync_ff <= ack_meta_ff;
    end
  end
  assign hs_busy = (hs_req_ff != ack_sync_ff);

  // ----------------------------------------
  // Link domain reset, configuration and pins
  // ----------------------------------------
  logic                  rst_meta_ff;
  logic                  link_rst_ff;
  adcls_pkg::adcls_cfg_t cfg_meta_ff;
  adcls_pkg::adcls_cfg_t cfg_l;
  logic [1:0]            pin_meta_ff;
  logic [1:0]            pin_sync_ff;
  logic                  strobe_lvl;
  logic                  strobe_q_ff;
  logic                  strobe_edge;

  always_ff @(posedge link_clk) begin
    rst_meta_ff <= sys_rst;
    link_rst_ff <= rst_meta_ff;
  end

  // Configuration fields are static while frames run, so a plain
  // two-stage copy per bit is enough.
  always_ff @(posedge link_clk) begin
    if (link_rst_ff) begin
      cfg_meta_ff <= '0;
      cfg_l       <= '0;
    end else begin
      cfg_meta_ff <= cfg_sys;
      cfg_l       <= cfg_meta_ff;
    end
  end

  always_ff @(posedge link_clk) begin
    if (link_rst_ff) begin
      pin_meta_ff <= 2'h0;
      pin_sync_ff <= 2'h0;
      strobe_q_ff <= 1'b0;
    end else begin
      pin_meta_ff <= {convert_strobe_p, convert_strobe_n};
      pin_sync_ff <= pin_meta_ff;
      strobe_q_ff <= strobe_lvl;
    end
  end
  // With the single-ended style the negative pin is grounded and ignored.
  assign strobe_lvl  = cfg_l.diff_strobe ? (pin_sync_ff[1] && !pin_sync_ff[0]) : pin_sync_ff[1];
  assign strobe_edge = strobe_lvl && !strobe_q_ff;

  // ----------------------------------------
  // Link side handshake capture
  // ----------------------------------------
  logic [2:0]          req_sync_ff;
  logic [RESULT_W-1:0] staged_ff;

  always_ff @(posedge link_clk) begin
    if (link_rst_ff) begin
      req_sync_ff <= 3'h0;
      ack_ff      <= 1'b0;
      staged_ff   <= '0;
    end else begin
      req_sync_ff <= {req_sync_ff[1:0], hs_req_ff};
      if (req_sync_ff[1] != req_sync_ff[2]) begin
        staged_ff <= hs_data_ff;
        ack_ff    <= req_sync_ff[1];
      end
    end
  end

  // ----------------------------------------
  // Load timing
  // ----------------------------------------
  function automatic logic [3:0] adcls_load_clocks(input logic [3:0] set, input logic dual);
    logic [3:0] clocks;
    clocks = 4'h1;
    if (dual) begin
      case (set)
        4'h0, 4'h1, 4'h2: clocks = set + 4'h3;
        4'h3, 4'h4:       clocks = set - 4'h2;
        default:          clocks = 4'h5;
      endcase
    end else begin
      case (set)
        4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7: clocks = set + 4'h3;
        4'h8, 4'h9: clocks = set - 4'h7;
        default:    clocks = 4'ha;
      endcase
    end
    return clocks;
  endfunction : adcls_load_clocks

  logic       wait_ff;
  logic [3:0] cnt_ff;
  logic [3:0] load_target;
  logic       load_pulse;

  assign load_target = adcls_load_clocks(cfg_l.load_cnt, cfg_l.two_lanes);
  assign load_pulse  = wait_ff && (cnt_ff == load_target);

  // A strobe during shifting restarts the wait, so the previous word keeps
  // shifting while the next conversion is under way.
  always_ff @(posedge link_clk) begin
    if (link_rst_ff) begin
      wait_ff <= 1'b0;
      cnt_ff  <= 4'h0;
    end else if (strobe_edge) begin
      wait_ff <= 1'b1;
      cnt_ff  <= 4'h1;
    end else if (load_pulse) begin
      wait_ff <= 1'b0;
    end else if (wait_ff) begin
      cnt_ff  <= cnt_ff + 4'h1;
    end
  end

  // ----------------------------------------
  // Shift register and lane pairs
  // ----------------------------------------
  logic                   manch_act;
  logic [RESULT_W-1:0]    src_word;
  logic [RESULT_W-1:0]    work_word;
  logic [RESULT_W-1:0]    sh_ff;
  logic [3:0]             rem_ff;
  adcls_pkg::adcls_shift_t sh_st_ff;
  adcls_pkg::adcls_pairs_t pairs_ff;
  adcls_pkg::adcls_pairs_t nxt_pairs;
  logic [3:0]             frame_clocks;

  assign manch_act = cfg_l.manch && cfg_l.two_lanes;
  assign src_word  = cfg_l.test_en ? adcls_pkg::TEST_PATTERN : staged_ff;
  assign work_word = load_pulse ? src_word : sh_ff;
  assign frame_clocks = manch_act ? adcls_pkg::CLK_MANCH :
                        (cfg_l.two_lanes ? adcls_pkg::CLK_DUAL : adcls_pkg::CLK_SINGLE);

  always_comb begin
    nxt_pairs = '0;
    if (load_pulse || sh_st_ff == adcls_pkg::SH_RUN) begin
      if (manch_act) begin
        nxt_pairs = {~work_word[19], work_word[19], ~work_word[18], work_word[18]};
      end else if (cfg_l.two_lanes) begin
        nxt_pairs = {work_word[19], work_word[17], work_word[18], work_word[16]};
      end else begin
        nxt_pairs = {work_word[19], work_word[18], 1'b0, 1'b0};
      end
    end
  end

  always_ff @(posedge link_clk) begin
    if (link_rst_ff) begin
      sh_st_ff <= adcls_pkg::SH_IDLE;
      sh_ff    <= '0;
      rem_ff   <= 4'h0;
      pairs_ff <= '0;
    end else begin
      pairs_ff <= nxt_pairs;
      if (load_pulse) begin
        sh_st_ff <= adcls_pkg::SH_RUN;
        rem_ff   <= frame_clocks - 4'h1;
      end else if (sh_st_ff == adcls_pkg::SH_RUN) begin
        rem_ff   <= rem_ff - 4'h1;
        if (rem_ff == 4'h1) begin
          sh_st_ff <= adcls_pkg::SH_IDLE;
        end
      end else begin
        sh_st_ff <= adcls_pkg::SH_IDLE;
      end
      if (manch_act || !cfg_l.two_lanes) begin
        sh_ff <= {work_word[RESULT_W-3:0], 2'b00};
      end else begin
        sh_ff <= {work_word[RESULT_W-5:0], 4'h0};
      end
    end
  end

  // ----------------------------------------
  // Double data rate output stage
  // ----------------------------------------
  // The low phase shows the bit chosen at the rising edge; the high phase
  // shows the rise bit, held over the falling edge so that the next rising
  // edge cannot disturb it.
  logic l1_hold_ff;
  logic l2_hold_ff;
  logic echo_en_ff;
  logic lane2_en_ff;

  always_ff @(negedge link_clk) begin
    l1_hold_ff <= pairs_ff.l1_rise;
    l2_hold_ff <= pairs_ff.l2_rise;
  end

  always_ff @(posedge link_clk) begin
    if (link_rst_ff) begin
      echo_en_ff  <= 1'b1;
      lane2_en_ff <= 1'b0;
    end else begin
      echo_en_ff  <= !cfg_l.self_clk;
      lane2_en_ff <= cfg_l.two_lanes;
    end
  end

  assign first_lane_p      = link_clk ? l1_hold_ff : pairs_ff.l1_fall;
  assign first_lane_n      = ~first_lane_p;
  assign second_lane_p     = lane2_en_ff && (link_clk ? l2_hold_ff : pairs_ff.l2_fall);
  assign second_lane_n     = ~second_lane_p;
  assign second_lane_en    = lane2_en_ff;
  assign echo_clock_out_p  = echo_en_ff && link_clk;
  assign echo_clock_out_n  = echo_en_ff && !link_clk;
  assign echo_clock_out_en = echo_en_ff;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  cfg_default_a: assert property (@(posedge clk_sys) sys_rst |=>
    (cfg_a_ff == adcls_pkg::RST_CFG_A) && (cfg_b_ff == adcls_pkg::RST_CFG_B))
    else $error("config not at reset value");
  buf_full_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (buf_cnt_ff == 2'h2) |-> !result_ready && !buf_push)
    else $error("buffer accepted while full");
  cmos_strobe_a: assert property (@(posedge link_clk) disable iff (link_rst_ff)
    !cfg_l.diff_strobe && pin_sync_ff[1] |=> strobe_q_ff)
    else $error("single-ended strobe missed");
  load_time_a: assert property (@(posedge link_clk) disable iff (link_rst_ff)
    load_pulse |-> (cnt_ff == load_target) && (cnt_ff == 4'h1 ? $past(strobe_edge) : $past(wait_ff)))
    else $error("result loaded at wrong clock");
  pattern_a: assert property (@(posedge link_clk) disable iff (link_rst_ff)
    load_pulse && cfg_l.test_en && !cfg_l.two_lanes |=>
    pairs_ff.l1_fall == adcls_pkg::TEST_PATTERN[19] && pairs_ff.l1_rise == adcls_pkg::TEST_PATTERN[18])
    else $error("test pattern not sent");
  single_frame_a: assert property (@(posedge link_clk) disable iff (link_rst_ff)
    load_pulse && !cfg_l.two_lanes |=>
    (sh_st_ff == adcls_pkg::SH_RUN)[*8] ##1 (sh_st_ff == adcls_pkg::SH_RUN && rem_ff == 4'h1))
    else $error("single lane frame too short");
  dual_frame_a: assert property (@(posedge link_clk) disable iff (link_rst_ff)
    load_pulse && cfg_l.two_lanes && !cfg_l.manch |=> rem_ff == 4'h4 ##4 rem_ff == 4'h0 || load_pulse)
    else $error("dual lane frame not five clocks");
  msb_first_a: assert property (@(posedge link_clk) disable iff (link_rst_ff)
    load_pulse && !cfg_l.two_lanes |=> pairs_ff.l1_fall == $past(src_word[19]))
    else $error("top bit not first");
  echo_off_a: assert property (@(posedge link_clk) disable iff (link_rst_ff)
    cfg_l.self_clk |=> !echo_clock_out_en)
    else $error("echo driver left on");
  manch_dc_a: assert property (@(posedge link_clk) disable iff (link_rst_ff)
    $past(manch_act) && $past(load_pulse || sh_st_ff == adcls_pkg::SH_RUN) |->
    pairs_ff.l1_fall != pairs_ff.l1_rise && pairs_ff.l2_fall != pairs_ff.l2_rise)
    else $error("manchester halves not balanced");
endmodule : adcls_serializer
`default_nettype wire

// *** verification/adcls_host_model.sv ***
`timescale 1ns/1ns
`default_nettype none
module adcls_host_model (
  // Link clock and convert strobe driven by the host
  output logic      link_clk,
  output logic      convert_strobe_p,
  output logic      convert_strobe_n,
  // Lanes and echo clock seen by the host
  input  wire logic first_lane_p,
  input  wire logic first_lane_n,
  input  wire logic second_lane_p,
  input  wire logic second_lane_n,
  input  wire logic echo_clock_out_p
);
  logic l1_s [0:127];
  logic l2_s [0:127];
  logic ec_s [0:127];
  int   n_samp = 0;
  int   pair_err = 0;
  int   hp = 24;

  initial begin
    link_clk = 1'b0;
    convert_strobe_p = 1'b0;
    convert_strobe_n = 1'b1;
  end

  // Samples sit mid-phase on the host's own clock, with no help from the echo.
  task automatic take;
    l1_s[n_samp] = first_lane_p;
    l2_s[n_samp] = second_lane_p;
    ec_s[n_samp] = echo_clock_out_p;
    if (first_lane_n !== ~first_lane_p || second_lane_n !== ~second_lane_p) pair_err++;
    if (n_samp < 127) n_samp++;
  endtask : take

  // The clock stands still outside bursts, as a gating host would leave it.
  task automatic run(input int n, input logic strb, input logic nl);
    if (strb) begin
      n_samp = 0;
      convert_strobe_p = 1'b1;
      convert_strobe_n = nl;
    end
    #(hp / 2);
    for (int i = 0; i < n; i++) begin
      link_clk = 1'b1;
      #(hp / 2) take();
      #(hp / 2) link_clk = 1'b0;
      if (i == 3) begin
        convert_strobe_p = 1'b0;
        convert_strobe_n = 1'b1;
      end
      #(hp / 2) take();
      #(hp / 2);
    end
  endtask : run
endmodule : adcls_host_model
`default_nettype wire

// *** verification/tb_top.sv ***
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  // ----------------------------------------
  // Design and host hookup
  // ----------------------------------------
  logic        clk_sys = 1'b0;
  logic        sys_rst = 1'b1;
  logic        reg_wr_en = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic [7:0]  reg_wdata = 8'h00;
  logic [7:0]  reg_rdata;
  logic        result_valid = 1'b0;
  logic [19:0] result_data = 20'h00000;
  logic        result_ready, link_clk, strb_p, strb_n;
  logic        l1_p, l1_n, l2_p, l2_n, l2_en, ec_p, ec_n, ec_en;
  logic        self_clk = 1'b0;
  int          bad_count = 0;
  int          n_compared = 0;
  int          j, j0, jb, k, k2;

  always #4 clk_sys = ~clk_sys;

  adcls_serializer adcls_serializer_i (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .reg_wr_en(reg_wr_en), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .result_valid(result_valid),
    .result_data(result_data), .result_ready(result_ready), .link_clk(link_clk),
    .convert_strobe_p(strb_p), .convert_strobe_n(strb_n), .first_lane_p(l1_p),
    .first_lane_n(l1_n), .second_lane_p(l2_p), .second_lane_n(l2_n), .second_lane_en(l2_en),
    .echo_clock_out_p(ec_p), .echo_clock_out_n(ec_n), .echo_clock_out_en(ec_en));

  adcls_host_model adcls_host_model_i (
    .link_clk(link_clk), .convert_strobe_p(strb_p), .convert_strobe_n(strb_n),
    .first_lane_p(l1_p), .first_lane_n(l1_n), .second_lane_p(l2_p),
    .second_lane_n(l2_n), .echo_clock_out_p(ec_p));

  // ----------------------------------------
  // Access tasks
  // ----------------------------------------
  task automatic test_done;
    if (bad_count == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : test_done

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr_en = 1'b1;
    @(posedge clk_sys);
    #1 reg_wr_en = 1'b0;
    @(posedge clk_sys);
    #1;
  endtask : reg_wr

  task automatic reg_rd(input logic [7:0] a, input logic [7:0] exp);
    reg_addr = a;
    repeat (2) @(posedge clk_sys);
    #1 check(reg_rdata, exp);
  endtask : reg_rd

  task automatic push(input logic [19:0] w, output int n);
    result_valid = 1'b1;
    result_data = w;
    n = 0;
    while (result_ready !== 1'b1) begin
      @(posedge clk_sys);
      #1 n++;
      if (n > 400) begin
        bad_count++;
        test_done();
      end
    end
    @(posedge clk_sys);
    #1 result_valid = 1'b0;
    @(posedge clk_sys);
    #1;
  endtask : push

  task automatic lclk(input int n);
    adcls_host_model_i.run(n, 1'b0, 1'b0);
  endtask : lclk

  task automatic cfg(input logic [7:0] a, input logic [7:0] b);
    reg_wr(adcls_pkg::OFS_CFG_A, a);
    reg_wr(adcls_pkg::OFS_CFG_B, b);
    self_clk = b[adcls_pkg::CFGB_SELF_BIT];
    adcls_host_model_i.hp = a[0] ? 48 : 24;
    lclk(4);
  endtask : cfg

  function automatic int tval(input int ln, input int c);
    if (ln == 0) return (c <= 7) ? c + 3 : (c == 8) ? 1 : (c == 9) ? 2 : 10;
    return (c <= 2) ? c + 3 : (c == 3) ? 1 : (c == 4) ? 2 : 5;
  endfunction : tval

  // Mode 0 single lane, 1 dual lane, 2 dual lane with Manchester coding.
  task automatic frame(input int md, input logic [19:0] w, input logic nl);
    adcls_host_model_i.run(30, 1'b1, nl);
    j = -1;
    for (int i = 59; i >= 1; i--) begin
      if (adcls_host_model_i.l1_s[i] === 1'b1) j = i;
    end
    check(l2_en, md != 0);
    check(ec_en, !self_clk);
    check(ec_n, !self_clk);
    for (int i = 0; i < 60; i++) begin
      check(adcls_host_model_i.ec_s[i], !self_clk && i % 2 == 0);
    end
    for (int m = 0; m < 20 && j >= 0; m++) begin
      if (md == 0) check({adcls_host_model_i.l1_s[j + m], adcls_host_model_i.l2_s[j + m]},
                         {w[19 - m], 1'b0});
      if (md == 1 && m < 10) check({adcls_host_model_i.l1_s[j + m], adcls_host_model_i.l2_s[j + m]},
                                   {w[19 - 2 * m], w[18 - 2 * m]});
      if (md == 2 && m < 10) check({adcls_host_model_i.l1_s[j + 2 * m - 1], adcls_host_model_i.l1_s[j + 2 * m],
                                    adcls_host_model_i.l2_s[j + 2 * m - 1], adcls_host_model_i.l2_s[j + 2 * m]},
                                   {~w[19 - 2 * m], w[19 - 2 * m], ~w[18 - 2 * m], w[18 - 2 * m]});
    end
  endtask : frame

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    fork
      lclk(4);
      repeat (8) @(posedge clk_sys);
    join
    @(posedge clk_sys);
    #1 sys_rst = 1'b0;
    @(posedge clk_sys);
    #1 reg_rd(adcls_pkg::OFS_CFG_A, adcls_pkg::RST_CFG_A);
    reg_rd(adcls_pkg::OFS_CFG_B, adcls_pkg::RST_CFG_B);
    reg_rd(8'h20, 8'h00);
    reg_wr(adcls_pkg::OFS_CFG_A, 8'hff);
    reg_rd(adcls_pkg::OFS_CFG_A, adcls_pkg::CFGA_MASK);
    reg_wr(adcls_pkg::OFS_CFG_B, 8'hff);
    reg_rd(adcls_pkg::OFS_CFG_B, adcls_pkg::CFGB_MASK);
    cfg(8'h00, 8'h00);
    push(20'h9a5c3, k);
    lclk(12);
    frame(0, 20'h9a5c3, 1'b0);
    check(j, 11);
    j0 = j;
    for (int ln = 0; ln < 2; ln++) begin
      for (int c = 0; c < 11; c++) begin
        cfg(8'h10 | 8'(ln), {c[3:0], 3'h0, c[0]});
        frame(ln, adcls_pkg::TEST_PATTERN, 1'b0);
        if (c == 0) jb = j;
        check(j, jb + 2 * (tval(ln, c) - 3));
      end
    end
    cfg(8'h00, 8'h00);
    push(20'hc3a5f, k);
    lclk(12);
    frame(0, 20'hc3a5f, 1'b0);
    check(j, j0);
    cfg(8'h01, 8'h00);
    push(20'hb5e21, k);
    lclk(12);
    frame(1, 20'hb5e21, 1'b0);
    cfg(8'h01, 8'h02);
    push(20'he7193, k);
    lclk(12);
    frame(2, 20'he7193, 1'b0);
    cfg(8'h00, 8'h02);
    frame(0, 20'he7193, 1'b0);
    check(j, j0);
    cfg(8'h00, 8'h08);
    frame(0, 20'he7193, 1'b1);
    check(j, -1);
    frame(0, 20'he7193, 1'b0);
    check(j, j0);
    cfg(8'h00, 8'h00);
    frame(0, 20'he7193, 1'b1);
    check(j, j0);
    // With the link stopped the buffer fills; the last word must survive the stall.
    push(20'h80001, k);
    push(20'h80002, k2);
    check(k + k2, 0);
    fork
      begin
        push(20'h80003, k);
        push(20'h8fff4, k2);
      end
      begin
        repeat (12) @(posedge clk_sys);
        lclk(20);
      end
    join
    check(k + k2 > 10, 1);
    lclk(20);
    check(result_ready, 1);
    frame(0, 20'h8fff4, 1'b0);
    check(adcls_host_model_i.pair_err, 0);
    test_done();
  end
endmodule : tb_top
`default_nettype wire
